// ---- nvm_page_buffer_and_crc.sv ----
// Flash and EEPROM page buffer sequencer with MISR flash checksum.
`timescale 1ns/10ps
module nvm_page_buffer_and_crc
    import nvm_seq_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                RST,
    input  wire logic                CMD_VALID,
    input  wire logic [3:0]          CMD,
    input  wire logic                CMD_FROM_EXT,
    input  wire logic [FADDR_W-1:0]  CMD_ADDR,
    input  wire logic [FADDR_W-1:0]  CMD_ADDR_END,
    input  wire logic [1:0]          CRC_SEL,
    input  wire logic [15:0]         CMD_DATA,
    input  wire logic                LOW_VOLTAGE_PIN,
    input  wire logic                CHIP_ERASE_ACTIVE,
    input  wire logic                PROGRAM_DEBUG_INTERFACE_EN,
    input  wire logic                NVM_DONE,
    input  wire logic [15:0]         FLASH_RD_DATA,
    output logic                     BUSY,
    output logic                     CPU_HALT,
    output logic                     BLOCK_READS,
    output logic                     BROWNOUT_MONITOR_FORCE,
    output logic                     NVM_ERASE,
    output logic                     NVM_WRITE,
    output logic                     NVM_EEPROM,
    output logic                     NVM_ABORT,
    output logic [FADDR_W-1:0]       NVM_ADDR,
    output logic [15:0]              NVM_WDATA,
    output logic [EBYTES-1:0]        EEPROM_BYTE_EN,
    output logic [FADDR_W-1:0]       FLASH_RD_ADDR,
    output logic [CRC_W-1:0]         CRC_RESULT,
    output logic                     CRC_DONE
);
    // Low-voltage indication and forcing straps come from analog/pin domains.
    logic [1:0] lv_sync_q;
    logic [1:0] ce_sync_q;
    logic [1:0] pdi_sync_q;
    always_ff @(posedge REF_CLK)
    begin
        lv_sync_q  <= {lv_sync_q[0], LOW_VOLTAGE_PIN};
        ce_sync_q  <= {ce_sync_q[0], CHIP_ERASE_ACTIVE};
        pdi_sync_q <= {pdi_sync_q[0], PROGRAM_DEBUG_INTERFACE_EN};
    end
    wire logic low_v = lv_sync_q[1];

    state_t                   state_q, state_d;
    logic [FADDR_W-1:0]       addr_q, addr_d;
    logic [FADDR_W-1:0]       end_q, end_d;
    logic [3:0]               op_q, op_d;
    logic                     erase_q, erase_d;
    logic                     write_q, write_d;
    logic                     eep_q, eep_d;
    logic                     abort_q, abort_d;
    logic [15:0]              wdata_q, wdata_d;
    logic [EBYTES-1:0]        ben_q, ben_d;
    logic [EBYTES-1:0]        tag_q, tag_d;
    logic [FW_AW-1:0]         widx_q, widx_d;
    logic                     wvalid_q, wvalid_d;
    logic [CRC_W-1:0]         misr_q, misr_d;
    logic [CRC_W-1:0]         crc_q, crc_d;
    logic                     crc_done_q, crc_done_d;
    logic                     crc_rd_q, crc_rd_d;
    logic                     crc_last_q, crc_last_d;
    logic [FADDR_W-1:0]       rd_addr_q, rd_addr_d;
    logic [FW_AW-1:0]         wword_q, wword_d;
    logic                     ephase_q, ephase_d;
    logic                     crc_dv_q, crc_dv_d;
    logic                     crc_dlast_q, crc_dlast_d;
    logic                     fclr, fld, eclr, eld;
    logic [15:0]              fbuf_rd;
    logic [7:0]               ebuf_rd;

    // Accepted only when idle; the source of the request is not consulted.
    wire logic take = CMD_VALID && state_q == ST_IDLE;

    nvm_buf_mem #(.W(16), .N(FWORDS), .AW(FW_AW)) u_fbuf (
        .clk     (REF_CLK),
        .clr     (fclr),
        .ld      (fld),
        .ld_addr (CMD_ADDR[FW_AW-1:0]),
        .ld_data (CMD_DATA),
        .rd_addr (widx_d),
        .rd_data (fbuf_rd)
    );

    nvm_buf_mem #(.W(8), .N(EBYTES), .AW(EB_AW)) u_ebuf (
        .clk     (REF_CLK),
        .clr     (eclr),
        .ld      (eld),
        .ld_addr (CMD_ADDR[EB_AW-1:0]),
        .ld_data (CMD_DATA[7:0]),
        .rd_addr (widx_d[EB_AW-1:0]),
        .rd_data (ebuf_rd)
    );

    // MISR step: shift left, fold bit 23 through the polynomial, xor in word.
    function automatic logic [CRC_W-1:0] misr_step(
        input logic [CRC_W-1:0] s,
        input logic [15:0]      w
    );
        logic [CRC_W-1:0] n;
        n = {s[CRC_W-2:0], 1'b0};
        if (s[CRC_W-1])
            n = n ^ CRC_POLY;
        return n ^ {8'h00, w};
    endfunction

    always_comb
    begin
        state_d    = state_q;
        addr_d     = addr_q;
        end_d      = end_q;
        op_d       = op_q;
        erase_d    = 1'b0;
        write_d    = 1'b0;
        eep_d      = eep_q;
        abort_d    = 1'b0;
        wdata_d    = wdata_q;
        ben_d      = '0;
        tag_d      = tag_q;
        widx_d     = widx_q;
        wvalid_d   = 1'b0;
        misr_d     = misr_q;
        crc_d      = crc_q;
        crc_done_d = 1'b0;
        crc_rd_d   = 1'b0;
        crc_last_d = 1'b0;
        rd_addr_d  = rd_addr_q;
        // The strobe leaving now carries the index read one cycle earlier.
        wword_d     = state_q == ST_FWRITE ? widx_q : '0;
        ephase_d    = ephase_q;
        crc_dv_d    = crc_rd_q;
        crc_dlast_d = crc_rd_q && crc_last_q;
        fclr       = RST;
        fld        = 1'b0;
        eclr       = RST;
        eld        = 1'b0;
        if (RST)
            tag_d = '0;
        case (state_q)
            ST_IDLE:
            begin
                widx_d = '0;
                if (take)
                begin
                    addr_d = CMD_ADDR;
                    op_d   = CMD;
                    case (CMD)
                        CMD_LD_FBUF:
                            fld = 1'b1;
                        CMD_CLR_FBUF:
                            fclr = 1'b1;
                        CMD_LD_EBUF:
                        begin
                            eld = 1'b1;
                            tag_d[CMD_ADDR[EB_AW-1:0]] = 1'b1;
                        end
                        CMD_CLR_EBUF:
                        begin
                            eclr  = 1'b1;
                            tag_d = '0;
                        end
                        CMD_ERASE_FPG, CMD_EWR_FPG:
                        begin
                            eep_d   = 1'b0;
                            erase_d = 1'b1;
                            state_d = ST_FERASE;
                        end
                        CMD_WRITE_FPG, CMD_SIG_WRITE:
                        begin
                            eep_d    = 1'b0;
                            wvalid_d = 1'b1;
                            state_d  = ST_FWRITE;
                        end
                        CMD_ERASE_EPG, CMD_WRITE_EPG, CMD_EWR_EPG:
                        begin
                            eep_d   = 1'b1;
                            erase_d = CMD != CMD_WRITE_EPG;
                            write_d = CMD == CMD_WRITE_EPG;
                            wdata_d = CMD == CMD_ERASE_EPG
                                    ? FWORD_ERASED
                                    : {8'h00, ebuf_rd};
                            ben_d   = tag_q;
                            ephase_d = 1'b0;
                            state_d = ST_EPROG;
                        end
                        CMD_LOCK_WRITE, CMD_FUSE_WRITE:
                        begin
                            write_d = 1'b1;
                            state_d = ST_MISC;
                        end
                        CMD_CRC:
                        begin
                            misr_d = CRC_ZERO;
                            if (CRC_SEL == CRC_APP)
                            begin
                                rd_addr_d = APP_FIRST;
                                end_d     = APP_LAST;
                            end
                            else if (CRC_SEL == CRC_BOOT)
                            begin
                                rd_addr_d = BOOT_FIRST;
                                end_d     = BOOT_LAST;
                            end
                            else
                            begin
                                rd_addr_d = CMD_ADDR;
                                end_d     = CMD_ADDR_END;
                            end
                            crc_rd_d = 1'b1;
                            crc_last_d = rd_addr_d == end_d;
                            state_d  = ST_CRC;
                        end
                        default:
                            op_d = CMD_NOP;
                    endcase
                end
            end
            ST_FERASE:
            begin
                if (NVM_DONE)
                begin
                    if (op_q == CMD_EWR_FPG)
                    begin
                        wvalid_d = 1'b1;
                        state_d  = ST_FWRITE;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_FWRITE:
            begin
                // Stream each buffer word to the array; one per cycle.
                if (wvalid_q)
                begin
                    write_d = 1'b1;
                    wdata_d = fbuf_rd;
                    if (widx_q != FW_AW'(FWORDS - 1))
                    begin
                        widx_d   = widx_q + 1'b1;
                        wvalid_d = 1'b1;
                    end
                end
                else if (NVM_DONE)
                begin
                    fclr    = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_EPROG:
            begin
                // Only byte lane 0 of the data bus carries EEPROM data.
                wdata_d = {8'h00, ebuf_rd};
                if (NVM_DONE)
                begin
                    if (op_q == CMD_EWR_EPG && !ephase_q)
                    begin
                        // Stay busy so the write half is guarded as well.
                        write_d  = 1'b1;
                        ben_d    = tag_q;
                        ephase_d = 1'b1;
                    end
                    else
                    begin
                        if (op_q != CMD_ERASE_EPG)
                        begin
                            eclr  = 1'b1;
                            tag_d = '0;
                        end
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_MISC:
            begin
                if (NVM_DONE)
                begin
                    fclr  = op_q == CMD_LOCK_WRITE;
                    eclr  = 1'b1;
                    tag_d = '0;
                    state_d = ST_IDLE;
                end
            end
            ST_CRC:
            begin
                // Addresses run one cycle ahead of the words they return.
                if (crc_rd_q && !crc_last_q)
                begin
                    rd_addr_d  = rd_addr_q + 1'b1;
                    crc_rd_d   = 1'b1;
                    crc_last_d = rd_addr_d == end_q;
                end
                if (crc_dv_q)
                    misr_d = misr_step(misr_q, FLASH_RD_DATA);
                if (crc_dlast_q)
                begin
                    crc_d      = misr_d;
                    crc_done_d = 1'b1;
                    state_d    = ST_IDLE;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        // Brownout during any programming ends it at once.
        if (low_v && state_q != ST_IDLE && state_q != ST_CRC)
        begin
            abort_d  = 1'b1;
            write_d  = 1'b0;
            erase_d  = 1'b0;
            wvalid_d = 1'b0;
            state_d  = ST_IDLE;
        end
        if (RST)
            state_d = ST_IDLE;
    end

    // State registers; every next value comes from the process above.
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_q    <= ST_IDLE;
            addr_q     <= '0;
            end_q      <= '0;
            op_q       <= CMD_NOP;
            erase_q    <= 1'b0;
            write_q    <= 1'b0;
            eep_q      <= 1'b0;
            abort_q    <= 1'b0;
            wdata_q    <= '0;
            ben_q      <= '0;
            tag_q      <= '0;
            widx_q     <= '0;
            wvalid_q   <= 1'b0;
            misr_q     <= CRC_ZERO;
            crc_q      <= CRC_ZERO;
            crc_done_q <= 1'b0;
            crc_rd_q   <= 1'b0;
            crc_last_q <= 1'b0;
            rd_addr_q  <= '0;
            wword_q    <= '0;
            ephase_q   <= 1'b0;
            crc_dv_q   <= 1'b0;
            crc_dlast_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            addr_q     <= addr_d;
            end_q      <= end_d;
            op_q       <= op_d;
            erase_q    <= erase_d;
            write_q    <= write_d;
            eep_q      <= eep_d;
            abort_q    <= abort_d;
            wdata_q    <= wdata_d;
            ben_q      <= ben_d;
            tag_q      <= tag_d;
            widx_q     <= widx_d;
            wvalid_q   <= wvalid_d;
            misr_q     <= misr_d;
            crc_q      <= crc_d;
            crc_done_q <= crc_done_d;
            crc_rd_q   <= crc_rd_d;
            crc_last_q <= crc_last_d;
            rd_addr_q  <= rd_addr_d;
            wword_q    <= wword_d;
            ephase_q   <= ephase_d;
            crc_dv_q   <= crc_dv_d;
            crc_dlast_q <= crc_dlast_d;
        end
    end

    logic busy_q, halt_q, blk_q, bod_q;
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            busy_q <= 1'b0;
            halt_q <= 1'b0;
            blk_q  <= 1'b0;
            bod_q  <= 1'b0;
        end
        else
        begin
            busy_q <= state_d != ST_IDLE;
            halt_q <= state_d == ST_CRC;
            blk_q  <= state_d != ST_IDLE && state_d != ST_CRC;
            bod_q  <= ce_sync_q[1] || pdi_sync_q[1];
        end
    end

    assign BUSY                   = busy_q;
    assign CPU_HALT               = halt_q;
    assign BLOCK_READS            = blk_q;
    assign BROWNOUT_MONITOR_FORCE = bod_q;
    assign NVM_ERASE              = erase_q;
    assign NVM_WRITE              = write_q;
    assign NVM_EEPROM             = eep_q;
    assign NVM_ABORT              = abort_q;
    assign NVM_ADDR               = {addr_q[FADDR_W-1:FW_AW], wword_q};
    assign NVM_WDATA              = wdata_q;
    assign EEPROM_BYTE_EN         = ben_q;
    assign FLASH_RD_ADDR          = rd_addr_q;
    assign CRC_RESULT             = crc_q;
    assign CRC_DONE               = crc_done_q;

    a_crc_halt_release: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CRC_DONE |-> !CPU_HALT)
        else $error("CPU still halted after checksum posted.");
    a_busy_ignores_cmd: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (BUSY && CMD_VALID && state_q != ST_IDLE) |=> $stable(op_q))
        else $error("Command taken while busy.");
    a_abort_on_lowv: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (low_v && state_q != ST_IDLE && state_q != ST_CRC) |=>
        NVM_ABORT && !BUSY)
        else $error("Programming not aborted on low voltage.");
    a_bod_forced: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (ce_sync_q[1] || pdi_sync_q[1]) |=> BROWNOUT_MONITOR_FORCE)
        else $error("Brownout monitor not forced on.");
    a_tag_on_load: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (take && CMD == CMD_LD_EBUF) |=>
        tag_q[$past(CMD_ADDR[EB_AW-1:0])])
        else $error("EEPROM load did not set its tag.");
    a_ebyte_en_tags: assert property (
        @(posedge REF_CLK) disable iff (RST)
        NVM_EEPROM && (NVM_WRITE || NVM_ERASE) |->
        (EEPROM_BYTE_EN & ~$past(tag_q)) == '0)
        else $error("Untagged EEPROM byte enabled.");
    a_crc_clear_start: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (take && CMD == CMD_CRC) |=> misr_q == CRC_ZERO)
        else $error("Signature register not cleared at start.");
    a_block_while_prog: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (NVM_WRITE || NVM_ERASE) |-> BLOCK_READS && BUSY)
        else $error("Reads not blocked during programming.");
endmodule

// ---- nvm_seq_pkg.sv ----
// Package of constants and types shared by the page buffer and CRC block.
// Operation
// - Flash buffer loads one 16-bit word each; requester clears it first.
// - Loading any buffer location stores old value AND new value.
// - Unloaded flash buffer words read and program as all ones.
// - Flash buffer clears after reset and flash page or lock writes.
// - EEPROM buffer loads one byte per load; requester clears first.
// - Loaded EEPROM bytes get a tag; page write and erase act on tags.
// - Untagged EEPROM bytes stay unchanged by page write and erase.
// - EEPROM erase ignores data values; locations must be loaded to tag.
// - EEPROM buffer, tags clear after reset, EEPROM page, lock, fuse writes.
// - Separate erase, separate write and atomic erase-write all supported.
// - Sequencing is identical for CPU and external programmer requests.
// - Low-voltage indication aborts any programming operation immediately.
// - Brownout monitor forced on during chip erase or debug interface use.
// - CRC over application section, boot section or explicit range.
// - CPU held halted during CRC; result placed before release (code posts it on the same clock edge as the release).
// - CRC consumes one flash word per clock cycle.
// - CRC is a MISR on 16-bit words, polynomial x^24+x^4+x^3+x+1.
// - Busy flag set and register writes ignored while operating.
// - Programming blocks other programming, buffer loads and section reads.
package nvm_seq_pkg;
    localparam int FWORDS     = 16;
    localparam int FW_AW      = 4;
    localparam int EBYTES     = 8;
    localparam int EB_AW      = 3;
    localparam int FPAGE_AW   = 8;
    localparam int EPAGE_AW   = 6;
    localparam int FADDR_W    = FPAGE_AW + FW_AW;
    localparam int CRC_W      = 24;
    localparam logic [15:0] FWORD_ERASED = 16'hFFFF;
    localparam logic [7:0]  EBYTE_ERASED = 8'hFF;
    localparam logic [CRC_W-1:0] CRC_POLY = 24'h00_001B;
    localparam logic [CRC_W-1:0] CRC_ZERO = 24'h00_0000;
    localparam logic [FADDR_W-1:0] APP_FIRST  = 12'h000;
    localparam logic [FADDR_W-1:0] APP_LAST   = 12'hDFF;
    localparam logic [FADDR_W-1:0] BOOT_FIRST = 12'hE00;
    localparam logic [FADDR_W-1:0] BOOT_LAST  = 12'hFFF;
    localparam logic [3:0] CMD_NOP        = 4'h0;
    localparam logic [3:0] CMD_LD_FBUF    = 4'h1;
    localparam logic [3:0] CMD_CLR_FBUF   = 4'h2;
    localparam logic [3:0] CMD_ERASE_FPG  = 4'h3;
    localparam logic [3:0] CMD_WRITE_FPG  = 4'h4;
    localparam logic [3:0] CMD_EWR_FPG    = 4'h5;
    localparam logic [3:0] CMD_SIG_WRITE  = 4'h6;
    localparam logic [3:0] CMD_LOCK_WRITE = 4'h7;
    localparam logic [3:0] CMD_FUSE_WRITE = 4'h8;
    localparam logic [3:0] CMD_LD_EBUF    = 4'h9;
    localparam logic [3:0] CMD_CLR_EBUF   = 4'hA;
    localparam logic [3:0] CMD_ERASE_EPG  = 4'hB;
    localparam logic [3:0] CMD_WRITE_EPG  = 4'hC;
    localparam logic [3:0] CMD_EWR_EPG    = 4'hD;
    localparam logic [3:0] CMD_CRC        = 4'hE;
    localparam logic [1:0] CRC_APP   = 2'h0;
    localparam logic [1:0] CRC_BOOT  = 2'h1;
    localparam logic [1:0] CRC_RANGE = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FERASE, ST_FWRITE, ST_EPROG, ST_MISC, ST_CRC
    } state_t;
endpackage

// ---- nvm_buf_mem.sv ----
// Word-wide page buffer storage with AND-merge load and registered read.
`timescale 1ns/10ps
module nvm_buf_mem
    import nvm_seq_pkg::*;
#(
    parameter int W  = 16,
    parameter int N  = 16,
    parameter int AW = 4
)(
    input  wire logic          clk,
    input  wire logic          clr,
    input  wire logic          ld,
    input  wire logic [AW-1:0] ld_addr,
    input  wire logic [W-1:0]  ld_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem_q [N];
    logic [W-1:0] mem_d [N];

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_loc
            always_comb
            begin
                mem_d[i] = mem_q[i];
                if (clr)
                    mem_d[i] = '1;
                else if (ld && ld_addr == AW'(i))
                    mem_d[i] = mem_q[i] & ld_data;
            end
            always_ff @(posedge clk)
            begin
                mem_q[i] <= mem_d[i];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        rd_data <= mem_q[rd_addr];
    end
endmodule

// ---- nvm_array_model.sv ----
// Array model: completion pulses after program strobes; word reads return data one cycle later.
`timescale 1ns/10ps
module nvm_array_model
    import nvm_seq_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               slow,
    input  wire logic               erase,
    input  wire logic               write,
    input  wire logic [FADDR_W-1:0] rd_addr,
    output logic                    done,
    output logic [15:0]             rd_data
);
    int cnt = -1;
    initial done = 1'b0;
    // Completion follows the last strobe of a burst, so bursts of any length
    // are answered once; the slow setting leaves room for an abort.
    always @(posedge clk)
    begin
        rd_data <= {4'hA, rd_addr};
        done <= 1'b0;
        if (erase || write)
            cnt <= slow ? 40 : 2;
        else if (cnt == 0)
        begin
            done <= 1'b1;
            cnt <= -1;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// ---- nvm_page_buffer_and_crc_tb.sv ----
// Self-checking bench for the page buffer sequencer and checksum engine.
`timescale 1ns/10ps
module nvm_page_buffer_and_crc_tb;
    import nvm_seq_pkg::*;
    logic REF_CLK = 0, RST = 1, CMD_VALID = 0, CMD_FROM_EXT = 0, slow = 0;
    logic LOW_VOLTAGE_PIN = 0, CHIP_ERASE_ACTIVE = 0;
    logic PROGRAM_DEBUG_INTERFACE_EN = 0, NVM_DONE;
    logic [3:0] CMD = 4'h0;
    logic [1:0] CRC_SEL = 2'h0;
    logic [15:0] CMD_DATA = 16'h0000, FLASH_RD_DATA, NVM_WDATA;
    logic [11:0] CMD_ADDR = 12'h000, CMD_ADDR_END = 12'h000;
    logic [11:0] NVM_ADDR, FLASH_RD_ADDR;
    logic BUSY, CPU_HALT, BLOCK_READS, BROWNOUT_MONITOR_FORCE, NVM_ERASE;
    logic NVM_WRITE, NVM_EEPROM, NVM_ABORT, CRC_DONE;
    logic [7:0] EEPROM_BYTE_EN;
    logic [23:0] CRC_RESULT;
    int n_mismatch = 0, checked = 0, cycles = 0;
    nvm_page_buffer_and_crc dut (.*);
    nvm_array_model u_array (.clk(REF_CLK), .slow(slow), .erase(NVM_ERASE),
        .write(NVM_WRITE), .rd_addr(FLASH_RD_ADDR), .done(NVM_DONE),
        .rd_data(FLASH_RD_DATA));
    initial forever #5 REF_CLK = ~REF_CLK;
    task automatic conclude();
        $display("compared %0d, mismatched %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A hung handshake must still reach the verdict.
    always @(posedge REF_CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input logic [11:0] a,
                       input logic [15:0] d);
        @(posedge REF_CLK);
        CMD <= c;
        CMD_ADDR <= a;
        CMD_DATA <= d;
        CMD_VALID <= 1'b1;
        @(posedge REF_CLK);
        CMD_VALID <= 1'b0;
    endtask
    // Waits at falling edges, where registered outputs have settled.
    task automatic wait_for(input int which, input int lim);
        logic s;
        for (int i = 0; i <= lim; i++)
        begin
            @(negedge REF_CLK);
            case (which)
                0: s = NVM_ERASE;
                1: s = NVM_WRITE;
                2: s = NVM_ABORT;
                3: s = CRC_DONE;
                4: s = BROWNOUT_MONITOR_FORCE;
                default: s = ~BUSY;
            endcase
            if (s === 1'b1)
                break;
        end
        chk(s, 1'b1);
    endtask
    task automatic grab_page(input logic [11:0] base, input logic [15:0] w0,
                             input logic [15:0] w15);
        wait_for(1, 300);
        for (int i = 0; i < FWORDS; i++)
        begin
            chk(NVM_WRITE, 1'b1);
            chk(NVM_ADDR, base + 12'(i));
            chk(NVM_WDATA, i == 0 ? w0 : i == 15 ? w15 : FWORD_ERASED);
            @(negedge REF_CLK);
        end
        wait_for(5, 200);
    endtask
    task automatic t_flash();
        cmd(CMD_CLR_FBUF, 12'h350, 16'h0000);
        cmd(CMD_LD_FBUF, 12'h350, 16'h1234);
        cmd(CMD_LD_FBUF, 12'h350, 16'h0F0F);
        cmd(CMD_LD_FBUF, 12'h35F, 16'hABCD);
        cmd(CMD_ERASE_FPG, 12'h350, 16'h0000);
        wait_for(0, 5);
        wait_for(5, 200);
        cmd(CMD_WRITE_FPG, 12'h350, 16'h0000);
        grab_page(12'h350, 16'h0204, 16'hABCD);
        @(posedge REF_CLK);
        CMD_FROM_EXT <= 1'b1;
        cmd(CMD_EWR_FPG, 12'h7A0, 16'h0000);
        wait_for(0, 5);
        grab_page(12'h7A0, FWORD_ERASED, FWORD_ERASED);
        @(posedge REF_CLK);
        CMD_FROM_EXT <= 1'b0;
        $display("test flash pages finished");
    endtask
    task automatic t_eeprom();
        cmd(CMD_CLR_EBUF, 12'h200, 16'h0000);
        cmd(CMD_LD_EBUF, 12'h201, 16'h0055);
        cmd(CMD_LD_EBUF, 12'h206, 16'h000F);
        cmd(CMD_WRITE_EPG, 12'h200, 16'h0000);
        wait_for(1, 300);
        chk(EEPROM_BYTE_EN, 8'h42);
        chk(NVM_EEPROM, 1'b1);
        wait_for(5, 200);
        cmd(CMD_LD_EBUF, 12'h203, 16'h0000);
        cmd(CMD_ERASE_EPG, 12'h200, 16'h0000);
        wait_for(0, 5);
        chk(EEPROM_BYTE_EN, 8'h08);
        wait_for(5, 200);
        $display("test eeprom tags finished");
    endtask
    task automatic t_crc(input logic [1:0] sel, input logic [11:0] lo,
                         input logic [11:0] hi);
        logic [23:0] s;
        s = CRC_ZERO;
        for (int a = lo; a <= hi; a++)
            s = {s[22:0], 1'b0} ^ (s[23] ? CRC_POLY : CRC_ZERO)
                ^ {8'h00, 4'hA, 12'(a)};
        @(posedge REF_CLK);
        CRC_SEL <= sel;
        CMD_ADDR_END <= hi;
        cmd(CMD_CRC, lo, 16'h0000);
        @(negedge REF_CLK);
        chk(CPU_HALT, 1'b1);
        chk(FLASH_RD_ADDR, lo);
        if (sel == CRC_RANGE)
            cmd(CMD_CRC, 12'h000, 16'h0000);
        wait_for(3, hi - lo + 3);
        chk(CRC_RESULT, s);
        @(negedge REF_CLK);
        chk(CPU_HALT, 1'b0);
        $display("test checksum mode %0d finished", sel);
    endtask
    task automatic t_power();
        slow <= 1'b1;
        cmd(CMD_ERASE_FPG, 12'h120, 16'h0000);
        wait_for(0, 5);
        chk(BLOCK_READS, 1'b1);
        @(posedge REF_CLK);
        LOW_VOLTAGE_PIN <= 1'b1;
        wait_for(2, 6);
        wait_for(5, 60);
        @(posedge REF_CLK);
        LOW_VOLTAGE_PIN <= 1'b0;
        slow <= 1'b0;
        CHIP_ERASE_ACTIVE <= 1'b1;
        wait_for(4, 6);
        @(posedge REF_CLK);
        CHIP_ERASE_ACTIVE <= 1'b0;
        repeat (6) @(posedge REF_CLK);
        PROGRAM_DEBUG_INTERFACE_EN <= 1'b1;
        @(negedge REF_CLK);
        chk(BROWNOUT_MONITOR_FORCE, 1'b0);
        wait_for(4, 6);
        $display("test supply guard finished");
    endtask
    initial
    begin
        repeat (20) @(posedge REF_CLK);
        RST <= 1'b0;
        t_flash();
        t_eeprom();
        t_crc(CRC_RANGE, 12'h040, 12'h041);
        t_crc(CRC_BOOT, BOOT_FIRST, BOOT_LAST);
        t_crc(CRC_APP, APP_FIRST, APP_LAST);
        t_power();
        conclude();
    end
endmodule
